// [verilog/sync_serial_shift_core.sv]
`timescale 1ns/1ps
module sync_serial_shift_core (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        serial_clock_in,
  output logic             serial_clock_out,
  output logic             serial_clock_oe_out,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_out,
  input  wire logic        arbitration_lost_in,
  output logic             irq_out
);

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;

  logic [15:0] ctrl_reg;
  logic [15:0] baud_reload;
  logic [15:0] transmit_buffer;
  logic [15:0] receive_buffer;
  logic [3:0]  interrupt_enables;
  logic        transmit_empty_flag;
  logic        receive_full_flag;
  logic        transmit_error_flag;
  logic        receive_error_flag;

  sync_serial_pkg::frame_state_t state;
  logic [15:0] shift_reg;
  logic [4:0]  bit_cnt;
  logic        pending;
  logic        rx_bit;
  logic        sampling;
  logic [2:0]  samp_cnt;
  logic [1:0]  samp_hold;
  logic [3:0]  clk_hist;
  logic        clk_run;
  logic [15:0] baud_cnt;
  logic [5:0]  half_cnt;
  logic        sclk_level;
  logic        data_out;

  sync_serial_pkg::ctrl_t   ctrl;
  sync_serial_pkg::status_t status_flags;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
    return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  assign ctrl = sync_serial_pkg::ctrl_t'({ctrl_reg[sync_serial_pkg::CTRL_WIDTH_LSB +: 4],
                                          ctrl_reg[sync_serial_pkg::CTRL_PHASE_BIT],
                                          ctrl_reg[sync_serial_pkg::CTRL_POL_BIT],
                                          ctrl_reg[sync_serial_pkg::CTRL_LOOP_BIT],
                                          ctrl_reg[sync_serial_pkg::CTRL_MSB_BIT],
                                          ctrl_reg[sync_serial_pkg::CTRL_MASTER_BIT],
                                          ctrl_reg[sync_serial_pkg::CTRL_ENABLE_BIT]});

  // frame geometry
  wire [4:0]  frame_bits  = {1'b0, ctrl.frame_width_field} + 5'h01;
  wire [15:0] width_mask  = 16'((17'h00001 << frame_bits) - 17'h00001);
  wire [15:0] top_bit     = 16'(17'h00001 << ctrl.frame_width_field);
  wire [5:0]  frame_halves = {frame_bits, 1'b0};

  // register bus decode
  wire wr_fire   = aw_held && w_held && !bvalid;
  wire rd_fire   = s_axi_arvalid_in && !rvalid;
  wire wr_ctrl   = wr_fire && (aw_addr == sync_serial_pkg::OFF_CTRL);
  wire wr_baud   = wr_fire && (aw_addr == sync_serial_pkg::OFF_BAUD);
  wire wr_tx     = wr_fire && (aw_addr == sync_serial_pkg::OFF_TXBUF);
  wire wr_ien    = wr_fire && (aw_addr == sync_serial_pkg::OFF_IEN);
  wire wr_known  = wr_ctrl || wr_baud || wr_tx || wr_ien ||
                   (aw_addr == sync_serial_pkg::OFF_RXBUF) || (aw_addr == sync_serial_pkg::OFF_STATUS);
  wire rd_rx     = rd_fire && (s_axi_araddr_in == sync_serial_pkg::OFF_RXBUF);

  assign s_axi_awready_out = !aw_held && !bvalid;
  assign s_axi_wready_out  = !w_held && !bvalid;
  assign s_axi_arready_out = !rvalid;
  assign s_axi_bvalid_out  = bvalid;
  assign s_axi_bresp_out   = bresp;
  assign s_axi_rvalid_out  = rvalid;
  assign s_axi_rresp_out   = rresp;
  assign s_axi_rdata_out   = rdata;

  // read data select
  logic [31:0] rd_value;
  logic        rd_known;
  always_comb begin
    rd_value = 32'h00000000;
    rd_known = 1'b1;
    if (s_axi_araddr_in == sync_serial_pkg::OFF_CTRL) begin
      rd_value = {16'h0000, ctrl_reg};
    end else if (s_axi_araddr_in == sync_serial_pkg::OFF_BAUD) begin
      rd_value = {16'h0000, baud_reload};
    end else if (s_axi_araddr_in == sync_serial_pkg::OFF_TXBUF) begin
      rd_value = {16'h0000, transmit_buffer};
    end else if (s_axi_araddr_in == sync_serial_pkg::OFF_RXBUF) begin
      rd_value = {16'h0000, receive_buffer};
    end else if (s_axi_araddr_in == sync_serial_pkg::OFF_STATUS) begin
      rd_value = {27'h0000000, status_flags};
    end else if (s_axi_araddr_in == sync_serial_pkg::OFF_IEN) begin
      rd_value = {28'h0000000, interrupt_enables};
    end else begin
      rd_known = 1'b0;
    end
  end

  assign status_flags = '{busy:                (state == sync_serial_pkg::FRAME_ACTIVE) || clk_run,
                          receive_error_flag:  receive_error_flag,
                          transmit_error_flag: transmit_error_flag,
                          receive_full_flag:   receive_full_flag,
                          transmit_empty_flag: transmit_empty_flag};

  // one combined line; each source gated by its own enable
  assign irq_out = |(status_flags[3:0] & interrupt_enables);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= sync_serial_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_known ? sync_serial_pkg::RESP_OKAY : sync_serial_pkg::RESP_SLVERR;
      end else if (bvalid && s_axi_bready_in) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rvalid <= 1'b0;
      rresp  <= sync_serial_pkg::RESP_OKAY;
      rdata  <= 32'h00000000;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp  <= rd_known ? sync_serial_pkg::RESP_OKAY : sync_serial_pkg::RESP_SLVERR;
      rdata  <= rd_value;
    end else if (rvalid && s_axi_rready_in) begin
      rvalid <= 1'b0;
    end
  end

  // configuration registers; lost arbitration overrides a same-cycle write
  wire [15:0] ctrl_written = merge16(ctrl_reg, w_data, w_strb) & sync_serial_pkg::CTRL_MASK;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ctrl_reg          <= sync_serial_pkg::CTRL_RESET;
      baud_reload       <= sync_serial_pkg::BAUD_RESET;
      interrupt_enables <= sync_serial_pkg::IEN_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_written;
      end
      if (arbitration_lost_in) begin
        ctrl_reg[sync_serial_pkg::CTRL_MASTER_BIT] <= 1'b0;
      end
      if (wr_baud) begin
        baud_reload <= merge16(baud_reload, w_data, w_strb);
      end
      if (wr_ien) begin
        interrupt_enables <= w_data[3:0] & {4{w_strb[0]}};
      end
    end
  end

  // serial clock edge detection on the clock actually in use
  wire clk_source = ctrl.master_select ? sclk_level : serial_clock_in;
  wire clk_prev   = maj3(clk_hist[3], clk_hist[2], clk_hist[1]);
  wire clk_cur    = maj3(clk_hist[2], clk_hist[1], clk_hist[0]);
  wire clk_edge   = clk_prev != clk_cur;
  wire lead_edge  = clk_edge && (clk_cur != ctrl.clock_polarity_select);
  wire trail_edge = clk_edge && (clk_cur == ctrl.clock_polarity_select);
  // latch in mid period, shift at period end
  wire latch_edge = ctrl.clock_phase_select ? trail_edge : lead_edge;
  wire shift_edge = ctrl.clock_phase_select ? lead_edge : trail_edge;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      clk_hist <= 4'h0;
    end else begin
      clk_hist <= {clk_hist[2:0], clk_source};
    end
  end

  // frame start conditions
  wire idle         = state == sync_serial_pkg::FRAME_IDLE;
  wire master_start = idle && ctrl.block_enable && ctrl.master_select &&
                      !transmit_empty_flag && !clk_run;
  wire slave_start  = idle && ctrl.block_enable && !ctrl.master_select && clk_edge;
  wire frame_start  = master_start || slave_start;
  wire frame_live   = ctrl.block_enable && (!idle || slave_start);

  // receive data path, pins ignored when disabled
  wire data_in = !ctrl.block_enable ? 1'b0 :
                 (ctrl.loopback_select ? data_out : serial_data_in);
  wire sampled = maj3(samp_hold[1], samp_hold[0], data_in);
  wire bit_ready = sampling && (samp_cnt == sync_serial_pkg::SAMPLE_LAST);
  wire last_bit  = (bit_cnt + 5'h01) == frame_bits;

  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b, input logic msb,
                                           input logic [15:0] mask, input logic [15:0] top);
    return msb ? (((sr << 1) & mask) | {15'h0000, b})
               : (((sr & mask) >> 1) | (b ? top : 16'h0000));
  endfunction : shift_in

  wire [15:0] final_word = shift_in(shift_reg, sampled, ctrl.msb_first_select, width_mask, top_bit);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !frame_live) begin
      sampling  <= 1'b0;
      samp_cnt  <= 3'h0;
      samp_hold <= 2'h0;
    end else if (latch_edge) begin
      sampling <= 1'b1;
      samp_cnt <= 3'h1;
    end else if (sampling) begin
      samp_cnt <= samp_cnt + 3'h1;
      sampling <= !bit_ready;
      if (samp_cnt >= sync_serial_pkg::SAMPLE_FIRST) begin
        samp_hold <= {samp_hold[0], data_in};
      end
    end
  end

  // frame sequencing and shift register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state     <= sync_serial_pkg::FRAME_IDLE;
      shift_reg <= 16'h0000;
      bit_cnt   <= 5'h00;
      pending   <= 1'b0;
      rx_bit    <= 1'b0;
    end else if (!ctrl.block_enable) begin
      state   <= sync_serial_pkg::FRAME_IDLE;
      pending <= 1'b0;
    end else if (frame_start) begin
      state     <= sync_serial_pkg::FRAME_ACTIVE;
      shift_reg <= transmit_buffer;
      bit_cnt   <= 5'h00;
      pending   <= 1'b0;
    end else if (!idle) begin
      if (bit_ready && last_bit) begin
        shift_reg <= final_word;
        state     <= sync_serial_pkg::FRAME_IDLE;
        pending   <= 1'b0;
      end else if (bit_ready) begin
        rx_bit  <= sampled;
        pending <= 1'b1;
        bit_cnt <= bit_cnt + 5'h01;
      end else if (shift_edge && pending) begin
        shift_reg <= shift_in(shift_reg, rx_bit, ctrl.msb_first_select, width_mask, top_bit);
        pending   <= 1'b0;
      end
    end
  end

  wire frame_done = ctrl.block_enable && !idle && bit_ready && last_bit;

  // buffers and flags; hardware set wins over the software clear
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      transmit_buffer     <= 16'h0000;
      receive_buffer      <= 16'h0000;
      transmit_empty_flag <= 1'b1;
      receive_full_flag   <= 1'b0;
      transmit_error_flag <= 1'b0;
      receive_error_flag  <= 1'b0;
    end else begin
      if (wr_tx) begin
        transmit_buffer     <= merge16(transmit_buffer, w_data, w_strb) & width_mask;
        transmit_empty_flag <= 1'b0;
        transmit_error_flag <= 1'b0;
      end
      if (frame_start) begin
        transmit_empty_flag <= 1'b1;
      end
      if (slave_start && transmit_empty_flag) begin
        transmit_error_flag <= 1'b1;
      end
      if (rd_rx) begin
        receive_full_flag  <= 1'b0;
        receive_error_flag <= 1'b0;
      end
      if (frame_done) begin
        receive_buffer    <= final_word & width_mask;
        receive_full_flag <= 1'b1;
        if (receive_full_flag && !rd_rx) begin
          receive_error_flag <= 1'b1;
        end
      end
    end
  end

  // master clock generator: baud_reload cycles per half period
  wire half_end  = baud_cnt <= 16'h0001;
  wire [5:0] next_half = half_cnt + 6'h01;
  wire next_active = ctrl.clock_phase_select ? !next_half[0] : next_half[0];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      clk_run    <= 1'b0;
      baud_cnt   <= sync_serial_pkg::BAUD_RESET;
      half_cnt   <= 6'h00;
      sclk_level <= 1'b0;
    end else if (!ctrl.block_enable || !ctrl.master_select) begin
      clk_run    <= 1'b0;
      sclk_level <= ctrl.clock_polarity_select;
    end else if (master_start) begin
      clk_run    <= 1'b1;
      baud_cnt   <= baud_reload;
      half_cnt   <= 6'h00;
      sclk_level <= ctrl.clock_polarity_select ^ ctrl.clock_phase_select;
    end else if (clk_run) begin
      if (half_end) begin
        baud_cnt <= baud_reload;
        half_cnt <= next_half;
        if (next_half == frame_halves) begin
          clk_run    <= 1'b0;
          sclk_level <= ctrl.clock_polarity_select;
        end else begin
          sclk_level <= ctrl.clock_polarity_select ^ next_active;
        end
      end else begin
        baud_cnt <= baud_cnt - 16'h0001;
      end
    end else begin
      sclk_level <= ctrl.clock_polarity_select;
    end
  end

  // output bit: idle slave presents its first bit ahead of the remote clock
  wire [15:0] out_word = idle ? transmit_buffer : shift_reg;
  wire out_bit = ctrl.msb_first_select ? |(out_word & top_bit) : out_word[0];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      data_out <= 1'b0;
    end else begin
      data_out <= ctrl.block_enable ? out_bit : 1'b0;
    end
  end

  assign serial_data_out     = data_out;
  assign serial_data_oe_out  = ctrl.block_enable && !ctrl.loopback_select;
  assign serial_clock_out    = sclk_level;
  assign serial_clock_oe_out = ctrl.block_enable && ctrl.master_select;

endmodule : sync_serial_shift_core

// [verilog/sync_serial_pkg.sv]
package sync_serial_pkg;

  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TXBUF  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RXBUF  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IEN    = 8'h14;

  // control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_MSB_BIT    = 2;
  localparam int CTRL_LOOP_BIT   = 3;
  localparam int CTRL_POL_BIT    = 4;
  localparam int CTRL_PHASE_BIT  = 5;
  localparam int CTRL_WIDTH_LSB  = 8;

  localparam logic [15:0] CTRL_MASK  = 16'h0F3F;
  localparam logic [15:0] CTRL_RESET = 16'h0700;
  localparam logic [15:0] BAUD_RESET = 16'h0008;
  localparam logic [3:0]  IEN_RESET  = 4'h0;

  // receive sampling window, in system clock periods after the latching edge
  localparam logic [2:0] SAMPLE_FIRST = 3'h3;
  localparam logic [2:0] SAMPLE_LAST  = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] frame_width_field;
    logic       clock_phase_select;
    logic       clock_polarity_select;
    logic       loopback_select;
    logic       msb_first_select;
    logic       master_select;
    logic       block_enable;
  } ctrl_t;

  typedef struct packed {
    logic busy;
    logic receive_error_flag;
    logic transmit_error_flag;
    logic receive_full_flag;
    logic transmit_empty_flag;
  } status_t;

  typedef enum logic [0:0] {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } frame_state_t;

endpackage : sync_serial_pkg

// [tb/sync_serial_shift_core_props.sv]
`timescale 1ns/1ps
module sync_serial_shift_core_props (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        serial_clock_oe_out,
  input wire logic        arbitration_lost_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_write_answer:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
                     |=> ##1 s_axi_bvalid_out)
      else $error("write not answered");
  chk_aw_hold:
    assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
      else $error("address taken twice");
  chk_read_answer:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read not answered");
  chk_bresp_stand:
    assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
  chk_rdata_stand:
    assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
  chk_write_refuse:
    assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken during response");
  chk_read_refuse:
    assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read taken during response");
  chk_unmapped_read:
    assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in > 8'h17
                     |=> s_axi_rvalid_out && s_axi_rresp_out == sync_serial_pkg::RESP_SLVERR)
      else $error("unmapped read unanswered");
  chk_arb_clear:
    assert property (arbitration_lost_in |=> !serial_clock_oe_out)
      else $error("master kept after lost arbitration");
endmodule : sync_serial_shift_core_props
bind sync_serial_shift_core sync_serial_shift_core_props chk_u (.clock_in, .rst_n_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .s_axi_rresp_out, .serial_clock_oe_out, .arbitration_lost_in);

// [tb/remote_serial_model.sv]
`timescale 1ns/1ps
module remote_serial_model #(
  parameter int HALF = 16
) (
  input  wire logic        clock_in,
  input  wire logic        drive_clock_in,
  input  wire logic        load_in,
  input  wire logic [15:0] word_in,
  input  wire logic [4:0]  bits_in,
  input  wire logic        peer_clock_in,
  input  wire logic        peer_data_in,
  output logic             sclk_out,
  output logic             data_out,
  output logic [15:0]      capture_out
);
  logic [15:0] shift;
  logic [5:0]  halves;
  logic [4:0]  left;
  logic [7:0]  div;
  logic        act_d;
  wire         act = drive_clock_in ? sclk_out : peer_clock_in;
  initial begin
    {sclk_out, data_out, act_d, halves, left, div, shift, capture_out} = '0;
  end
  always @(posedge clock_in) begin
    act_d <= act;
    if (load_in) begin
      shift  <= word_in << (5'h10 - bits_in);
      left   <= bits_in;
      halves <= {bits_in, 1'b0};
      div    <= 8'h00;
    end else begin
      // shift on the trailing edge so data is settled at the latching edge
      if (act_d && !act) begin
        shift <= shift << 1;
        left  <= left - 5'h01;
      end
      if (!act_d && act) capture_out <= {capture_out[14:0], peer_data_in};
      // clock only runs within a frame
      if (drive_clock_in && halves != 6'h00) begin
        div <= (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
        if (div == 8'(HALF - 1)) begin
          sclk_out <= ~sclk_out;
          halves   <= halves - 6'h01;
        end
      end
    end
    // a released line toggles so a stale bit never looks valid
    data_out <= (left != 5'h00) ? shift[15] : ~data_out;
  end
endmodule : remote_serial_model

// [tb/sync_serial_shift_core_tb.sv]
`timescale 1ns/1ps
module sync_serial_shift_core_tb;
  logic        clock_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, serial_clock_in, serial_clock_out, serial_clock_oe_out, serial_data_in;
  logic        serial_data_out, serial_data_oe_out, arbitration_lost_in, irq_out, drive_clock, load;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d, x, y;
  logic [31:0] seed = 32'h5DE1DCD4;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r;
  logic [15:0] word, capture;
  logic [4:0]  bits;
  int          n_fail = 0;
  int          total_checks = 0;
  int          i;
  sync_serial_shift_core dut_u (.*);
  remote_serial_model #(.HALF(16)) peer_u (.clock_in, .drive_clock_in(drive_clock), .load_in(load),
    .word_in(word), .bits_in(bits), .peer_clock_in(serial_clock_out), .peer_data_in(serial_data_out),
    .sclk_out(serial_clock_in), .data_out(serial_data_in), .capture_out(capture));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] msk(input logic [31:0] v, input logic [3:0] f);
    return v & ((32'h1 << (f + 5'h01)) - 32'h1);
  endfunction : msk
  function automatic logic [31:0] rev8(input logic [7:0] v);
    logic [31:0] o = '0;
    for (int k = 0; k < 8; k++) o[k] = v[7-k];
    return o;
  endfunction : rev8
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int   n;
    logic aw, w, b;
    @(posedge clock_in);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock_in);
      aw = s_axi_awready_out;
      w  = s_axi_wready_out;
      b  = s_axi_bvalid_out;
      @(posedge clock_in);
      if (aw) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
      if (b && s_axi_bready_in) break;
      if (b) s_axi_bready_in <= 1'b1;
    end
    s_axi_bready_in <= 1'b0;
    if (n == 50) begin
      chk("write_wait", 1, 0);
      print_verdict();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int   n;
    logic ar, rv;
    @(posedge clock_in);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock_in);
      ar = s_axi_arready_out;
      rv = s_axi_rvalid_out;
      v  = s_axi_rdata_out;
      rr = s_axi_rresp_out;
      @(posedge clock_in);
      if (ar) s_axi_arvalid_in <= 1'b0;
      if (rv && s_axi_rready_in) break;
      if (rv) s_axi_rready_in <= 1'b1;
    end
    s_axi_rready_in <= 1'b0;
    if (n == 50) begin
      chk("read_wait", 1, 0);
      print_verdict();
    end
  endtask : rd
  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      rd(sync_serial_pkg::OFF_STATUS, d, r);
      if (d[b] === v) break;
    end
    chk("status_bit", 32'(v), 32'(d[b]));
    if (n == 300) print_verdict();
  endtask : poll
  task automatic peer(input logic dc, input logic [15:0] w);
    // let the tail of the previous serial clock die out before reloading
    repeat (40) @(posedge clock_in);
    @(posedge clock_in);
    drive_clock <= dc;
    word        <= w;
    load        <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
  endtask : peer
  initial begin
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, drive_clock, load, word} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {rst_n_in, arbitration_lost_in} = '0;
    s_axi_wstrb_in = 4'hF;
    bits = 5'h08;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(sync_serial_pkg::OFF_CTRL, d, r);
    chk("ctrl_reset", 32'(sync_serial_pkg::CTRL_RESET), d);
    rd(sync_serial_pkg::OFF_STATUS, d, r);
    chk("status_reset", 32'h1, d);
    rd(8'h40, d, r);
    chk("unmapped_resp", 32'(sync_serial_pkg::RESP_SLVERR), 32'(r));
    wr(sync_serial_pkg::OFF_BAUD, 32'h10);
    // loopback master through widths of 2 to 16 bits, both bit orders
    for (i = 1; i < 16; i++) begin
      poll(4, 1'b0);
      // polarity and phase vary too; the clock must be idle before they change
      wr(sync_serial_pkg::OFF_CTRL, {20'h00000, i[3:0], 2'h0, i[1], i[2], 1'b1, i[0], 2'h3});
      x = rnd();
      wr(sync_serial_pkg::OFF_TXBUF, x);
      rd(sync_serial_pkg::OFF_TXBUF, d, r);
      chk("tx_mask", msk(x, i[3:0]), d);
      poll(1, 1'b1);
      chk("tx_empty", 1, 32'(d[0]));
      rd(sync_serial_pkg::OFF_RXBUF, d, r);
      chk("loop_rx", msk(x, i[3:0]), msk(d, i[3:0]));
    end
    wr(sync_serial_pkg::OFF_IEN, 32'h8);
    wr(sync_serial_pkg::OFF_TXBUF, rnd());
    poll(1, 1'b1);
    chk("irq_gated", 0, 32'(irq_out));
    x = rnd();
    wr(sync_serial_pkg::OFF_TXBUF, x);
    poll(3, 1'b1);
    chk("irq_rx_err", 1, 32'(irq_out));
    rd(sync_serial_pkg::OFF_RXBUF, d, r);
    chk("rx_overwrite", msk(x, 4'hF), msk(d, 4'hF));
    poll(3, 1'b0);
    chk("irq_clear", 0, 32'(irq_out));
    for (i = 0; i < 2; i++) begin
      wr(sync_serial_pkg::OFF_CTRL, {20'h00000, 4'h7, 5'h00, i[0], 2'h3});
      x = rnd();
      y = rnd();
      peer(1'b0, y[15:0]);
      wr(sync_serial_pkg::OFF_TXBUF, x);
      poll(1, 1'b1);
      rd(sync_serial_pkg::OFF_RXBUF, d, r);
      chk("data_oe", 1, 32'(serial_data_oe_out));
      chk("rx_pin", i[0] ? 32'(y[7:0]) : rev8(y[7:0]), 32'(d[7:0]));
      chk("tx_pin", i[0] ? 32'(x[7:0]) : rev8(x[7:0]), 32'(capture[7:0]));
    end
    @(posedge clock_in);
    arbitration_lost_in <= 1'b1;
    @(posedge clock_in);
    arbitration_lost_in <= 1'b0;
    rd(sync_serial_pkg::OFF_CTRL, d, r);
    chk("arb_slave", 0, 32'(d[1]));
    x = rnd();
    wr(sync_serial_pkg::OFF_TXBUF, x);
    y = rnd();
    peer(1'b1, y[15:0]);
    poll(1, 1'b1);
    chk("tx_err_none", 0, 32'(d[2]));
    rd(sync_serial_pkg::OFF_RXBUF, d, r);
    chk("slave_rx", 32'(y[7:0]), 32'(d[7:0]));
    chk("slave_tx", 32'(x[7:0]), 32'(capture[7:0]));
    peer(1'b1, y[15:0]);
    poll(2, 1'b1);
    wr(sync_serial_pkg::OFF_TXBUF, x);
    poll(2, 1'b0);
    wr(sync_serial_pkg::OFF_CTRL, 32'h0700);
    @(negedge clock_in);
    chk("pins_off", 0, 32'({serial_data_oe_out, serial_clock_oe_out, serial_data_out, serial_clock_out}));
    print_verdict();
  end
endmodule : sync_serial_shift_core_tb
